// file: logic/pmbpn_defines.svh
// constants for the protect / nvm / output-voltage command block
// assumes inclusion by bare name from every logic file that needs it
`ifndef PMBPN_DEFINES_SVH
`define PMBPN_DEFINES_SVH

`define PMBPN_CMD_OPERATION   8'h01
`define PMBPN_CMD_ON_OFF_CFG  8'h02
`define PMBPN_CMD_WRITE_LOCK  8'h10
`define PMBPN_CMD_SAVE        8'h11
`define PMBPN_CMD_RELOAD      8'h12
`define PMBPN_CMD_FEATURE     8'h19
`define PMBPN_CMD_FORMAT      8'h20
`define PMBPN_CMD_SETPOINT    8'h21
`define PMBPN_CMD_CEILING     8'h24
`define PMBPN_CMD_OC_FAULT    8'h46
`define PMBPN_CMD_OC_WARN     8'h4A

`define PMBPN_LOCK_ALL        8'h80
`define PMBPN_LOCK_OPER       8'h40
`define PMBPN_LOCK_CFG        8'h20
`define PMBPN_LOCK_NONE       8'h00
`define PMBPN_LOCK_KEEP_MASK  8'hE0

`define PMBPN_FEATURE_VALUE   8'hB0
`define PMBPN_FORMAT_MODE_VID 3'h1
`define PMBPN_FORMAT_PAR_T2   5'h02
`define PMBPN_FORMAT_PAR_T1   5'h01

`define PMBPN_CEILING_RESET   8'hFF
`define PMBPN_OC_QUARTER_SH   2

`define PMBPN_ITEM_SETPOINT   2'h0
`define PMBPN_ITEM_CEILING    2'h1
`define PMBPN_ITEM_OC_FAULT   2'h2
`define PMBPN_ITEM_OC_WARN    2'h3

`endif

// file: logic/pmbpn_pkg.sv
// shared types for the protect / nvm / output-voltage command block
// assumes nothing beyond a SystemVerilog compiler
package pmbpn_pkg;

    typedef enum logic [1:0] {
        PMBPN_LVL_NONE,
        PMBPN_LVL_ALL,
        PMBPN_LVL_OPER,
        PMBPN_LVL_CFG
    } pmbpn_lock_e;

    typedef enum logic [2:0] {
        PMBPN_ST_IDLE,
        PMBPN_ST_SAVE,
        PMBPN_ST_LOAD_RD,
        PMBPN_ST_LOAD_WR,
        PMBPN_ST_POST
    } pmbpn_seq_e;

endpackage

// file: logic/pmbpn_write_gate.sv
// write-lock decode: turns the lock byte and a command code into a permit
// assumes lock byte and code are stable on the same clock as the caller
`include "pmbpn_defines.svh"

module pmbpn_write_gate
    import pmbpn_pkg::*;
#(
    parameter bit CFG_LEVEL_ALLOWS_SETPOINT = 1'b0
) (
    input  wire logic [7:0] lock_byte,    // stored lock byte
    input  wire logic [7:0] code,         // command code being written
    output logic            permit,       // write may proceed
    output logic            lock_invalid  // lock byte holds an unusable pattern
);

    function automatic pmbpn_lock_e lock_level(input logic [7:0] b);
        unique case (b)
            `PMBPN_LOCK_ALL:  lock_level = PMBPN_LVL_ALL;
            `PMBPN_LOCK_OPER: lock_level = PMBPN_LVL_OPER;
            `PMBPN_LOCK_CFG:  lock_level = PMBPN_LVL_CFG;
            default:          lock_level = PMBPN_LVL_NONE;
        endcase
    endfunction

    pmbpn_lock_e level;

    always_comb begin
        level = lock_level(lock_byte);
        lock_invalid = (lock_byte != `PMBPN_LOCK_ALL) && (lock_byte != `PMBPN_LOCK_OPER)
                       && (lock_byte != `PMBPN_LOCK_CFG) && (lock_byte != `PMBPN_LOCK_NONE);
        unique case (level)
            PMBPN_LVL_ALL:  permit = (code == `PMBPN_CMD_WRITE_LOCK);
            PMBPN_LVL_OPER: permit = (code == `PMBPN_CMD_WRITE_LOCK)
                                     || (code == `PMBPN_CMD_OPERATION);
            // the two descriptions of this level disagree on the setpoint; a parameter picks
            PMBPN_LVL_CFG:  permit = (code == `PMBPN_CMD_WRITE_LOCK)
                                     || (code == `PMBPN_CMD_OPERATION)
                                     || (code == `PMBPN_CMD_ON_OFF_CFG)
                                     || (CFG_LEVEL_ALLOWS_SETPOINT
                                         && (code == `PMBPN_CMD_SETPOINT));
            // invalid patterns fall here too and protect nothing
            PMBPN_LVL_NONE: permit = 1'b1;
        endcase
    end

endmodule // pmbpn_write_gate

// file: logic/pmbpn_nvm_store.sv
// nonvolatile default store model: synchronous write, registered read
// assumes contents survive reset; no reset clears the array
module pmbpn_nvm_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             ref_clk,  // controller clock
    input  wire logic             wr_en,    // write strobe
    input  wire logic [AW-1:0]    wr_addr,  // write slot
    input  wire logic [WIDTH-1:0] wr_data,  // write word
    input  wire logic             rd_en,    // read strobe
    input  wire logic [AW-1:0]    rd_addr,  // read slot
    output logic      [WIDTH-1:0] rd_data   // word, one cycle after rd_en
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // pmbpn_nvm_store

// file: logic/pmbpn_cmd_regs.sv
// command registers: write lock, save/reload to nvm, feature and format bytes,
// output-voltage setpoint with ceiling clamp
// assumes a serial-bus slave on ref_clk hands over one decoded command per cmd_stb
`include "pmbpn_defines.svh"

module pmbpn_cmd_regs
    import pmbpn_pkg::*;
#(
    parameter int NVM_DEPTH                 = 8,
    parameter int NVM_AW                    = 3,
    parameter int N_ITEMS                   = 4,
    parameter bit CFG_LEVEL_ALLOWS_SETPOINT = 1'b0
) (
    input  wire logic        ref_clk,                // controller clock, 50 MHz
    input  wire logic        rst,                    // synchronous reset, active high
    input  wire logic        cmd_stb,                // one-cycle command strobe
    input  wire logic        cmd_write,              // 1 write, 0 read
    input  wire logic [7:0]  cmd_code,               // command code
    input  wire logic [15:0] cmd_data,               // write data, low byte first on bus
    input  wire logic        clear_faults,           // one-cycle flag clear
    input  wire logic        slew_select_pin,        // table select pin, asynchronous
    input  wire logic        vendor_table_valid,     // vendor config overrides pin
    input  wire logic        vendor_table_sel,       // vendor config table choice
    input  wire logic [7:0]  maximum_current,        // maximum_current code
    input  wire logic [7:0]  boot_voltage,           // boot vid code
    output logic             rsp_stb,                // one-cycle answer strobe
    output logic [15:0]      rsp_data,               // read data
    output logic             rsp_rejected,           // write refused
    output logic             rsp_foreign,            // code not held here
    output logic             nvm_busy,               // save or reload in progress
    output logic [7:0]       setpoint_vid,           // clamped vid to regulation loop
    output logic [7:0]       output_voltage_ceiling, // ceiling vid
    output logic [15:0]      overcurrent_fault_limit,   // fault limit
    output logic [15:0]      overcurrent_warning_limit, // warning limit
    output logic             second_vid_table,       // 1 second table, 0 first
    output logic             communication_flag,     // sticky
    output logic             unsupported_data_flag,  // sticky
    output logic             output_voltage_ceiling_warning        // sticky
);

    logic [7:0]  write_lock_control;
    logic [7:0]  output_voltage_setpoint;
    logic        slew_meta;
    logic        slew_sync;
    logic        permit;
    logic        lock_invalid;
    pmbpn_seq_e  seq;
    logic [NVM_AW-1:0] idx;
    logic [NVM_AW-1:0] idx_d;
    logic        nvm_wr_en;
    logic        nvm_rd_en;
    logic [15:0] nvm_wr_data;
    logic [15:0] nvm_rd_data;
    logic        wr_req;
    logic        rd_req;
    logic        wr_ok;
    logic        wr_lock;
    logic        wr_setpoint;
    logic        wr_ceiling;
    logic        wr_oc_fault;
    logic        wr_oc_warn;
    logic        wr_readonly;
    logic        wr_seq_start;
    logic        set_cml;
    logic        set_usd;
    logic        set_vmax;
    logic        load_item;
    logic        post_save;
    logic [15:0] oc_fault_default;
    logic [15:0] next_rsp_data;

    function automatic logic is_held(input logic [7:0] c);
        is_held = (c == `PMBPN_CMD_WRITE_LOCK) || (c == `PMBPN_CMD_SAVE)
                  || (c == `PMBPN_CMD_RELOAD) || (c == `PMBPN_CMD_FEATURE)
                  || (c == `PMBPN_CMD_FORMAT) || (c == `PMBPN_CMD_SETPOINT)
                  || (c == `PMBPN_CMD_CEILING) || (c == `PMBPN_CMD_OC_FAULT)
                  || (c == `PMBPN_CMD_OC_WARN);
    endfunction

    // slot index -> true if that slot maps onto an operating item
    function automatic logic slot_matched(input logic [NVM_AW-1:0] s);
        slot_matched = (int'(s) < N_ITEMS);
    endfunction

    pmbpn_write_gate #(
        .CFG_LEVEL_ALLOWS_SETPOINT (CFG_LEVEL_ALLOWS_SETPOINT)
    ) u_gate (
        .lock_byte    (write_lock_control),
        .code         (cmd_code),
        .permit       (permit),
        .lock_invalid (lock_invalid)
    );

    pmbpn_nvm_store #(
        .WIDTH (16),
        .DEPTH (NVM_DEPTH),
        .AW    (NVM_AW)
    ) u_store (
        .ref_clk (ref_clk),
        .wr_en   (nvm_wr_en),
        .wr_addr (idx),
        .wr_data (nvm_wr_data),
        .rd_en   (nvm_rd_en),
        .rd_addr (idx),
        .rd_data (nvm_rd_data)
    );

    always_ff @(posedge ref_clk) begin
        slew_meta <= slew_select_pin;
        slew_sync <= slew_meta;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            second_vid_table <= 1'b0;
        end else begin
            second_vid_table <= vendor_table_valid ? vendor_table_sel : slew_sync;
        end
    end

    // request decode; writes during a save or reload are refused whole
    always_comb begin
        wr_req       = cmd_stb && cmd_write;
        rd_req       = cmd_stb && !cmd_write;
        wr_ok        = wr_req && permit && (seq == PMBPN_ST_IDLE);
        wr_lock      = wr_ok && (cmd_code == `PMBPN_CMD_WRITE_LOCK);
        wr_setpoint  = wr_ok && (cmd_code == `PMBPN_CMD_SETPOINT);
        wr_ceiling   = wr_ok && (cmd_code == `PMBPN_CMD_CEILING);
        wr_oc_fault  = wr_ok && (cmd_code == `PMBPN_CMD_OC_FAULT);
        wr_oc_warn   = wr_ok && (cmd_code == `PMBPN_CMD_OC_WARN);
        wr_readonly  = wr_req && ((cmd_code == `PMBPN_CMD_FORMAT)
                                  || (cmd_code == `PMBPN_CMD_FEATURE));
        wr_seq_start = wr_ok && ((cmd_code == `PMBPN_CMD_SAVE)
                                 || (cmd_code == `PMBPN_CMD_RELOAD));
    end

    // flag sources; a new lock byte is judged as it is written
    always_comb begin
        set_usd  = wr_readonly
                   || (wr_lock && ((cmd_data[7:0] & `PMBPN_LOCK_KEEP_MASK) != cmd_data[7:0]))
                   || (wr_lock && (cmd_data[7:0] != `PMBPN_LOCK_ALL)
                       && (cmd_data[7:0] != `PMBPN_LOCK_OPER)
                       && (cmd_data[7:0] != `PMBPN_LOCK_CFG)
                       && (cmd_data[7:0] != `PMBPN_LOCK_NONE));
        set_cml  = set_usd || (wr_req && !wr_ok && is_held(cmd_code));
        set_vmax = wr_setpoint && (cmd_data[7:0] > output_voltage_ceiling);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            write_lock_control <= `PMBPN_LOCK_NONE;
        end else if (wr_lock) begin
            // only the three level bits are kept
            write_lock_control <= cmd_data[7:0] & `PMBPN_LOCK_KEEP_MASK;
        end
    end

    // save / reload sequencer; save takes one item per cycle, reload two cycles per slot
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seq   <= PMBPN_ST_IDLE;
            idx   <= '0;
            idx_d <= '0;
        end else begin
            idx_d <= idx;
            unique case (seq)
                PMBPN_ST_IDLE: begin
                    idx <= '0;
                    if (wr_seq_start) begin
                        seq <= (cmd_code == `PMBPN_CMD_SAVE) ? PMBPN_ST_SAVE
                                                             : PMBPN_ST_LOAD_RD;
                    end
                end
                PMBPN_ST_SAVE: begin
                    if (int'(idx) == N_ITEMS - 1) begin
                        seq <= PMBPN_ST_POST;
                    end else begin
                        idx <= idx + 1'b1;
                    end
                end
                PMBPN_ST_LOAD_RD: begin
                    seq <= PMBPN_ST_LOAD_WR;
                end
                PMBPN_ST_LOAD_WR: begin
                    if (int'(idx) == NVM_DEPTH - 1) begin
                        seq <= PMBPN_ST_IDLE;
                    end else begin
                        idx <= idx + 1'b1;
                        seq <= PMBPN_ST_LOAD_RD;
                    end
                end
                PMBPN_ST_POST: begin
                    seq <= PMBPN_ST_IDLE;
                end
                default: begin
                    seq <= PMBPN_ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        nvm_wr_en = (seq == PMBPN_ST_SAVE) && slot_matched(idx);
        nvm_rd_en = (seq == PMBPN_ST_LOAD_RD);
        unique case (idx[1:0])
            `PMBPN_ITEM_SETPOINT: nvm_wr_data = {8'h00, output_voltage_setpoint};
            `PMBPN_ITEM_CEILING:  nvm_wr_data = {8'h00, output_voltage_ceiling};
            `PMBPN_ITEM_OC_FAULT: nvm_wr_data = overcurrent_fault_limit;
            `PMBPN_ITEM_OC_WARN:  nvm_wr_data = overcurrent_warning_limit;
        endcase
        // stored slots with no operating item are simply dropped
        load_item = (seq == PMBPN_ST_LOAD_WR) && slot_matched(idx_d);
        post_save = (seq == PMBPN_ST_POST);
        oc_fault_default = {8'h00, maximum_current}
                           + {8'h00, maximum_current >> `PMBPN_OC_QUARTER_SH};
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            output_voltage_setpoint <= boot_voltage;
        end else if (post_save) begin
            output_voltage_setpoint <= boot_voltage;
        end else if (load_item && (idx_d[1:0] == `PMBPN_ITEM_SETPOINT)) begin
            output_voltage_setpoint <= nvm_rd_data[7:0];
        end else if (wr_setpoint) begin
            // above the ceiling the ceiling itself is taken
            output_voltage_setpoint <= set_vmax ? output_voltage_ceiling
                                                : cmd_data[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || post_save) begin
            output_voltage_ceiling <= `PMBPN_CEILING_RESET;
        end else if (load_item && (idx_d[1:0] == `PMBPN_ITEM_CEILING)) begin
            output_voltage_ceiling <= nvm_rd_data[7:0];
        end else if (wr_ceiling) begin
            output_voltage_ceiling <= cmd_data[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || post_save) begin
            overcurrent_fault_limit   <= oc_fault_default;
            overcurrent_warning_limit <= {8'h00, maximum_current};
        end else begin
            if (load_item && (idx_d[1:0] == `PMBPN_ITEM_OC_FAULT)) begin
                overcurrent_fault_limit <= nvm_rd_data;
            end else if (wr_oc_fault) begin
                overcurrent_fault_limit <= cmd_data;
            end
            if (load_item && (idx_d[1:0] == `PMBPN_ITEM_OC_WARN)) begin
                overcurrent_warning_limit <= nvm_rd_data;
            end else if (wr_oc_warn) begin
                overcurrent_warning_limit <= cmd_data;
            end
        end
    end

    // the ceiling may be lowered under a standing setpoint, so clamp again on the way out
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            setpoint_vid <= '0;
        end else begin
            setpoint_vid <= (output_voltage_setpoint > output_voltage_ceiling)
                            ? output_voltage_ceiling : output_voltage_setpoint;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nvm_busy <= 1'b0;
        end else begin
            nvm_busy <= wr_seq_start || ((seq != PMBPN_ST_IDLE)
                        && !(seq == PMBPN_ST_POST)
                        && !((seq == PMBPN_ST_LOAD_WR) && (int'(idx) == NVM_DEPTH - 1)));
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            communication_flag    <= 1'b0;
            unsupported_data_flag <= 1'b0;
            output_voltage_ceiling_warning      <= 1'b0;
        end else begin
            communication_flag    <= set_cml  || (communication_flag && !clear_faults);
            unsupported_data_flag <= set_usd  || (unsupported_data_flag && !clear_faults);
            output_voltage_ceiling_warning      <= set_vmax || (output_voltage_ceiling_warning && !clear_faults);
        end
    end

    always_comb begin
        next_rsp_data = '0;
        if (rd_req) begin
            unique case (cmd_code)
                `PMBPN_CMD_WRITE_LOCK: next_rsp_data = {8'h00, write_lock_control};
                `PMBPN_CMD_FEATURE:    next_rsp_data = {8'h00, `PMBPN_FEATURE_VALUE};
                `PMBPN_CMD_FORMAT:     next_rsp_data = {8'h00, `PMBPN_FORMAT_MODE_VID,
                                                        second_vid_table ? `PMBPN_FORMAT_PAR_T2
                                                                         : `PMBPN_FORMAT_PAR_T1};
                `PMBPN_CMD_SETPOINT:   next_rsp_data = {8'h00, output_voltage_setpoint};
                `PMBPN_CMD_CEILING:    next_rsp_data = {8'h00, output_voltage_ceiling};
                `PMBPN_CMD_OC_FAULT:   next_rsp_data = overcurrent_fault_limit;
                `PMBPN_CMD_OC_WARN:    next_rsp_data = overcurrent_warning_limit;
                default:               next_rsp_data = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsp_stb      <= 1'b0;
            rsp_data     <= '0;
            rsp_rejected <= 1'b0;
            rsp_foreign  <= 1'b0;
        end else begin
            rsp_stb      <= cmd_stb;
            rsp_data     <= next_rsp_data;
            rsp_rejected <= wr_req && (!wr_ok || wr_readonly);
            rsp_foreign  <= cmd_stb && !is_held(cmd_code);
        end
    end

endmodule // pmbpn_cmd_regs

// file: verif/pmbpn_cmd_regs_properties.sv
// port assertions for the command-register block
// assumes bind onto pmbpn_cmd_regs, one clock, synchronous reset
module pmbpn_cmd_regs_chk (
    input wire logic        ref_clk, rst, cmd_stb, cmd_write, rsp_stb, rsp_rejected,
    input wire logic        nvm_busy, second_vid_table, unsupported_data_flag,
    input wire logic [7:0]  cmd_code, setpoint_vid, output_voltage_ceiling,
    input wire logic [15:0] rsp_data
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic rd = cmd_stb && !cmd_write;
    wire logic wr = cmd_stb && cmd_write;
    a_answer_next_cycle: assert property (rsp_stb == $past(cmd_stb))
        else $error("answer strobe misplaced");
    a_feature_value: assert property (rd && cmd_code == 8'h19 |=> rsp_data == 16'h00B0)
        else $error("feature byte wrong");
    a_format_value:
        assert property (rd && cmd_code == 8'h20 |=> rsp_data ==
            {8'h00, 3'h1, $past(second_vid_table) ? 5'h02 : 5'h01})
        else $error("format byte wrong");
    a_lock_low_zero:
        assert property (rd && cmd_code == 8'h10 |=> rsp_data[15:8] == 8'h00
            && rsp_data[4:0] == 5'h00)
        else $error("lock reserved bits set");
    a_readonly_refused:
        assert property (wr && (cmd_code == 8'h19 || cmd_code == 8'h20)
            |=> rsp_rejected && unsupported_data_flag)
        else $error("read-only write accepted");
    // clamp output lags the ceiling register by one cycle
    a_clamp_ceiling: assert property (setpoint_vid <= $past(output_voltage_ceiling))
        else $error("setpoint above ceiling");
    a_busy_refuses: assert property (wr && nvm_busy |=> rsp_rejected)
        else $error("write accepted while busy");
    a_save_defaults:
        assert property (wr && cmd_code == 8'h11 && !nvm_busy ##1 !rsp_rejected
            |-> ##[1:10] output_voltage_ceiling == 8'hFF)
        else $error("ceiling not defaulted");
endmodule // pmbpn_cmd_regs_chk

bind pmbpn_cmd_regs pmbpn_cmd_regs_chk chk_u (.ref_clk, .rst, .cmd_stb, .cmd_write,
    .rsp_stb, .rsp_rejected, .nvm_busy, .second_vid_table, .unsupported_data_flag,
    .cmd_code, .setpoint_vid, .output_voltage_ceiling, .rsp_data);

// file: verif/pmbpn_host.sv
// host model of the command port: one command per call
// assumes the block answers on the taking edge itself, readable just after it
module pmbpn_host (
    input  wire logic        ref_clk,              // clock
    output logic             cmd_stb = 1'h0,       // strobe
    output logic             cmd_write = 1'h0,     // 1 write
    output logic [7:0]       cmd_code = 8'h00,     // code
    output logic [15:0]      cmd_data = 16'h0000,  // data word
    input  wire logic        rsp_stb,              // answer
    input  wire logic        rsp_rejected,         // refused
    input  wire logic [15:0] rsp_data              // read data
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic ok, output logic rj, output logic [15:0] q);
        logic [15:0] dd;
        dd = (c == 8'h11 || c == 8'h12) ? ~cmd_data : d;
        @(posedge ref_clk);
        #1;
        {cmd_stb, cmd_write, cmd_code, cmd_data} = {1'h1, w, c, dd};
        @(posedge ref_clk);
        #1;
        // released lines invert so a stale word never passes for a live one
        {cmd_stb, cmd_code, cmd_data} = {1'h0, ~c, ~dd};
        {ok, rj, q} = {rsp_stb, rsp_rejected, rsp_data};
    endtask
endmodule // pmbpn_host

// file: verif/tb_top.sv
// self-checking bench for the command-register block
// assumes the host model drives commands and the checker is bound
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic w; logic [7:0] c; logic [15:0] d; logic [16:0] e;} pmbpn_row_s;
    logic        ref_clk = 1'h0, rst = 1'h1, clear_faults = 1'h0;
    logic        slew_select_pin = 1'h0, vendor_table_valid = 1'h0, vendor_table_sel = 1'h0;
    logic        cmd_stb, cmd_write, rsp_stb, rsp_rejected, nvm_busy, second_vid_table;
    logic        communication_flag, unsupported_data_flag, output_voltage_ceiling_warning, ok, rj, foreign;
    logic [7:0]  cmd_code, setpoint_vid, output_voltage_ceiling;
    logic [15:0] cmd_data, rsp_data, oc_fault, oc_warn, q;
    int          miscompares = 0, checked = 0;
    // write, code, data, expected {refused, read data}
    pmbpn_row_s  rows [22] = '{
        '{1'h0, 8'h19, 16'h0, 17'h000B0}, '{1'h0, 8'h20, 16'h0, 17'h00021},
        '{1'h0, 8'h10, 16'h0, 17'h00000}, '{1'h1, 8'h21, 16'h40, 17'h0},
        '{1'h0, 8'h21, 16'h0, 17'h00040}, '{1'h1, 8'h20, 16'h55, 17'h10000},
        '{1'h1, 8'h19, 16'h55, 17'h10000}, '{1'h1, 8'h10, 16'h80, 17'h0},
        '{1'h1, 8'h21, 16'h30, 17'h10000}, '{1'h0, 8'h21, 16'h0, 17'h00040},
        '{1'h1, 8'h10, 16'h40, 17'h0}, '{1'h1, 8'h24, 16'h10, 17'h10000},
        '{1'h1, 8'h01, 16'h0, 17'h0}, '{1'h1, 8'h10, 16'h20, 17'h0},
        '{1'h1, 8'h02, 16'h0, 17'h0}, '{1'h1, 8'h21, 16'h33, 17'h10000},
        '{1'h1, 8'h10, 16'hFF, 17'h0}, '{1'h0, 8'h10, 16'h0, 17'h000E0},
        '{1'h1, 8'h24, 16'h50, 17'h0}, '{1'h1, 8'h10, 16'h0, 17'h0},
        '{1'h1, 8'h4A, 16'h1234, 17'h0}, '{1'h0, 8'h4A, 16'h0, 17'h01234}};
    always #10 ref_clk = ~ref_clk;
    pmbpn_host host_u (.ref_clk, .cmd_stb, .cmd_write, .cmd_code, .cmd_data, .rsp_stb,
        .rsp_rejected, .rsp_data);
    pmbpn_cmd_regs dut_u (.ref_clk, .rst, .cmd_stb, .cmd_write, .cmd_code, .cmd_data,
        .clear_faults, .slew_select_pin, .vendor_table_valid, .vendor_table_sel,
        .maximum_current(8'h40), .boot_voltage(8'h60), .rsp_stb, .rsp_data,
        .rsp_rejected, .rsp_foreign(foreign), .nvm_busy, .setpoint_vid, .output_voltage_ceiling,
        .overcurrent_fault_limit(oc_fault), .overcurrent_warning_limit(oc_warn),
        .second_vid_table, .communication_flag, .unsupported_data_flag, .output_voltage_ceiling_warning);
    task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d);
        host_u.xfer(w, c, d, ok, rj, q);
    endtask
    task automatic wait_idle;
        int i;
        for (i = 0; i < 40 && nvm_busy !== 1'h0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (i == 40) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        tk(16);
        rst = 1'h0;
        foreach (rows[i]) begin
            op(rows[i].w, rows[i].c, rows[i].d);
            chk("row", {ok, rj, q}, {1'h1, rows[i].e});
            chk("foreign", 18'(foreign), 18'(rows[i].c == 8'h01 || rows[i].c == 8'h02));
        end
        chk("flags", 18'({communication_flag, unsupported_data_flag}), 18'h3);
        clear_faults = 1'h1;
        tk(1);
        clear_faults = 1'h0;
        tk(1);
        chk("cleared", 18'({communication_flag, unsupported_data_flag}), 18'h0);
        $display("table done");
        op(1'h1, 8'h11, 16'h0);
        op(1'h1, 8'h21, 16'h11);
        chk("busy", 18'(rj), 18'h1);
        wait_idle();
        tk(3);
        chk("defaults", 18'({output_voltage_ceiling, setpoint_vid}), 18'h0FF60);
        chk("oc fault", 18'(oc_fault), 18'h00050);
        chk("oc warn", 18'(oc_warn), 18'h00040);
        op(1'h1, 8'h24, 16'h30);
        op(1'h1, 8'h12, 16'h0);
        wait_idle();
        tk(2);
        chk("ceiling", 18'(output_voltage_ceiling), 18'h00050);
        chk("reload warn", 18'(oc_warn), 18'h01234);
        op(1'h0, 8'h21, 16'h0);
        chk("stored", 18'(q), 18'h00040);
        $display("nvm done");
        op(1'h1, 8'h21, 16'h70);
        tk(1);
        chk("clamp", 18'({output_voltage_ceiling_warning, setpoint_vid}), 18'h00150);
        slew_select_pin = 1'h1;
        tk(4);
        op(1'h0, 8'h20, 16'h0);
        chk("pin table", 18'({second_vid_table, q}), 18'h10022);
        vendor_table_valid = 1'h1;
        tk(2);
        op(1'h0, 8'h20, 16'h0);
        chk("cfg table", 18'({second_vid_table, q}), 18'h00021);
        vendor_table_sel = 1'h1;
        tk(2);
        op(1'h0, 8'h20, 16'h0);
        chk("cfg second", 18'({second_vid_table, q}), 18'h10022);
        $display("tables done");
        rst = 1'h1;
        tk(3);
        rst = 1'h0;
        tk(2);
        chk("boot", 18'(setpoint_vid), 18'h00060);
        op(1'h0, 8'h10, 16'h0);
        chk("lock", 18'(q), 18'h0);
        $display("reset done");
        report_and_stop();
    end
endmodule // tb_top
